// >>> core/fbo_pkg.sv
// Shared constants for the flag branch and bit operation unit
package fbo_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int FBO_ADR_W = 10;      // Byte address width
    localparam int FBO_DAT_W = 32;      // Wishbone data width

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [9:0] FBO_OFS_CMD = 10'h000;   // Instruction word
    localparam logic [9:0] FBO_OFS_PC = 10'h004;    // Program counter
    localparam logic [9:0] FBO_OFS_STAT = 10'h008;  // Status register
    localparam logic [9:0] FBO_OFS_STATE = 10'h00C; // Execution state
    localparam logic [2:0] FBO_REGION_GPR = 3'h1;   // 0x080..0x0FC
    localparam logic [2:0] FBO_REGION_IO = 3'h2;    // 0x100..0x17C

    // ------------------------------------------------------------
    // Instruction word fields
    // ------------------------------------------------------------
    localparam int FBO_CMD_W = 19;      // Stored instruction bits
    localparam int FBO_OP_LSB = 0;      // Operation code, 4 bits
    localparam int FBO_IDX_LSB = 4;     // Register or I/O index, 5 bits
    localparam int FBO_SEL_LSB = 9;     // Bit or flag select, 3 bits
    localparam int FBO_K_LSB = 12;      // Signed branch offset, 7 bits

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    localparam logic [3:0] FBO_OP_NOP = 4'h0;
    localparam logic [3:0] FBO_OP_BR_H_SET = 4'h1;
    localparam logic [3:0] FBO_OP_BR_H_CLR = 4'h2;
    localparam logic [3:0] FBO_OP_BR_T_SET = 4'h3;
    localparam logic [3:0] FBO_OP_BR_T_CLR = 4'h4;
    localparam logic [3:0] FBO_OP_BR_V_SET = 4'h5;
    localparam logic [3:0] FBO_OP_BR_V_CLR = 4'h6;
    localparam logic [3:0] FBO_OP_BR_I_SET = 4'h7;
    localparam logic [3:0] FBO_OP_BR_I_CLR = 4'h8;
    localparam logic [3:0] FBO_OP_IO_SET = 4'h9;
    localparam logic [3:0] FBO_OP_IO_CLR = 4'hA;
    localparam logic [3:0] FBO_OP_SHL = 4'hB;
    localparam logic [3:0] FBO_OP_SHR = 4'hC;
    localparam logic [3:0] FBO_OP_ROT = 4'hD;
    localparam logic [3:0] FBO_OP_SWAP = 4'hE;
    localparam logic [3:0] FBO_OP_FLAG_SET = 4'hF;

    // ------------------------------------------------------------
    // Status register bit positions
    // ------------------------------------------------------------
    localparam int FBO_FLAG_C = 0;      // Carry
    localparam int FBO_FLAG_Z = 1;      // Zero
    localparam int FBO_FLAG_N = 2;      // Negative
    localparam int FBO_FLAG_V = 3;      // Overflow
    localparam int FBO_FLAG_H = 5;      // Half carry
    localparam int FBO_FLAG_T = 6;      // Transfer bit
    localparam int FBO_FLAG_I = 7;      // Global interrupt enable

    // ------------------------------------------------------------
    // Reset values and cycle counts
    // ------------------------------------------------------------
    localparam logic [15:0] FBO_PC_RST = 16'h0000;
    localparam logic [7:0] FBO_STAT_RST = 8'h00;
    localparam logic [7:0] FBO_BYTE_RST = 8'h00;
    localparam logic [1:0] FBO_CYC_ONE = 2'h1;
    localparam logic [1:0] FBO_CYC_TWO = 2'h2;

    // ------------------------------------------------------------
    // Address decode helpers
    // ------------------------------------------------------------
    function automatic logic fbo_in_region(input logic [9:0] adr,
                                           input logic [2:0] region);
        fbo_in_region = (adr[9:7] == region);
    endfunction

    function automatic logic [4:0] fbo_word_idx(input logic [9:0] adr);
        fbo_word_idx = adr[6:2];
    endfunction

endpackage

// >>> core/fbo_branch_unit.sv
// Branch condition test and next program counter
`timescale 1ns/10ps
module fbo_branch_unit (
    // Decoded instruction
    input wire logic [3:0] op_in,
    input wire logic [6:0] k_in,
    // Core state
    input wire logic [7:0] stat_in,
    input wire logic [15:0] pc_in,
    // Results
    output logic is_branch_out,
    output logic taken_out,
    output logic [15:0] next_pc_out
);
    import fbo_pkg::*;

    logic [15:0] pc_inc; // Address of the following instruction
    logic [15:0] k_ext;  // Sign extended offset

    // Condition test per branch kind
    always_comb begin
        is_branch_out = 1'b1;
        taken_out = 1'b0;
        case (op_in)
            FBO_OP_BR_H_SET: taken_out = stat_in[FBO_FLAG_H];
            FBO_OP_BR_H_CLR: taken_out = ~stat_in[FBO_FLAG_H];
            FBO_OP_BR_T_SET: taken_out = stat_in[FBO_FLAG_T];
            FBO_OP_BR_T_CLR: taken_out = ~stat_in[FBO_FLAG_T];
            FBO_OP_BR_V_SET: taken_out = stat_in[FBO_FLAG_V];
            FBO_OP_BR_V_CLR: taken_out = ~stat_in[FBO_FLAG_V];
            FBO_OP_BR_I_SET: taken_out = stat_in[FBO_FLAG_I];
            FBO_OP_BR_I_CLR: taken_out = ~stat_in[FBO_FLAG_I];
            default: is_branch_out = 1'b0;
        endcase
    end

    always_comb begin
        pc_inc = pc_in + 16'h0001;
        k_ext = {{9{k_in[6]}}, k_in};
        next_pc_out = taken_out ? pc_inc + k_ext : pc_inc;
    end

endmodule

// >>> core/fbo_bit_alu.sv
// Shift, rotate, swap, flag set and I/O bit results
`timescale 1ns/10ps
module fbo_bit_alu (
    // Decoded instruction
    input wire logic [3:0] op_in,
    input wire logic [2:0] sel_in,
    // Operands
    input wire logic [7:0] reg_in,
    input wire logic [7:0] io_in,
    input wire logic [7:0] stat_in,
    // Results
    output logic writes_reg_out,
    output logic [7:0] reg_out,
    output logic [7:0] io_out,
    output logic [7:0] stat_out
);
    import fbo_pkg::*;

    logic [7:0] mask;   // One-hot bit select
    logic carry;        // New carry for shifts
    logic shift_op;     // Shift or rotate in progress

    // Result and flag computation
    always_comb begin
        mask = 8'h01 << sel_in;
        writes_reg_out = 1'b1;
        reg_out = reg_in;
        carry = stat_in[FBO_FLAG_C];
        shift_op = 1'b1;
        stat_out = stat_in;
        case (op_in)
            FBO_OP_SHL: begin
                reg_out = {reg_in[6:0], 1'b0};
                carry = reg_in[7];
            end
            FBO_OP_SHR: begin
                reg_out = {1'b0, reg_in[7:1]};
                carry = reg_in[0];
            end
            FBO_OP_ROT: begin
                reg_out = {reg_in[6:0], stat_in[FBO_FLAG_C]};
                carry = reg_in[7];
            end
            FBO_OP_SWAP: begin
                reg_out = {reg_in[3:0], reg_in[7:4]};
                shift_op = 1'b0;
            end
            FBO_OP_FLAG_SET: begin
                writes_reg_out = 1'b0;
                shift_op = 1'b0;
                stat_out = stat_in | mask;
            end
            default: begin
                writes_reg_out = 1'b0;
                shift_op = 1'b0;
            end
        endcase
        // Shift flags: Z, C, N and V = N xor C
        if (shift_op) begin
            stat_out[FBO_FLAG_Z] = (reg_out == 8'h00);
            stat_out[FBO_FLAG_C] = carry;
            stat_out[FBO_FLAG_N] = reg_out[7];
            stat_out[FBO_FLAG_V] = reg_out[7] ^ carry;
        end
    end

    assign io_out = (op_in == FBO_OP_IO_SET) ? (io_in | mask)
                                             : (io_in & ~mask);

endmodule

// >>> core/fbo_core.sv
// Flag branch and bit operation unit with Wishbone register access
// How it works
// - Half carry set branch jumps PC+k+1
// - Half carry clear branch jumps PC+k+1
// - Transfer bit branches jump, flags untouched
// - Overflow set/clear branches, flags untouched
// - Interrupt enable branches, flags untouched
// - I/O bit set, two cycles, flags kept
// - I/O bit clear, two cycles, flags kept
// - Shift left, zero in, ZCNV, one cycle
// - Shift right, zero in, ZCNV, one cycle
// - Rotate left through carry, ZCNV, one cycle
// - Swap nibbles, no flags, one cycle
// - Set selected status flag, one cycle
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
module fbo_core (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    // Wishbone slave
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [fbo_pkg::FBO_ADR_W-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [fbo_pkg::FBO_DAT_W-1:0] WB_DAT_IN,
    output logic [fbo_pkg::FBO_DAT_W-1:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    // Execution status
    output logic BUSY_OUT
);
    import fbo_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC1, ST_EXEC2} fbo_state_t;

    fbo_state_t state_q;                // Execution sequencer
    fbo_state_t state_d;                // Next sequencer state
    logic [FBO_CMD_W-1:0] cmd_q;        // Instruction being executed
    logic [15:0] pc_q;                  // Program counter
    logic [7:0] stat_q;                 // Status register
    logic [7:0] gpr_q [32];             // Working registers
    logic [7:0] io_q [32];              // I/O registers
    logic [7:0] io_hold_q;              // I/O result awaiting write
    logic [1:0] last_cyc_q;             // Cycles of last instruction
    logic last_taken_q;                 // Last branch was taken
    logic busy_q;                       // Sequencer not idle
    logic ack_q;                        // Bus acknowledge
    logic [31:0] rd_data_q;             // Registered read data

    logic bus_req;                      // New bus access this cycle
    logic bus_wr;                       // New write access
    logic bus_wr_idle;                  // Write allowed to core state
    logic cmd_go;                       // Instruction accepted
    logic [31:0] rd_data;               // Read multiplexer
    logic [4:0] bus_idx;                // Word index inside a region
    logic wr_gpr;                       // Write hits working registers
    logic wr_io;                        // Write hits I/O registers

    logic [3:0] op;                     // Operation code
    logic [4:0] idx;                    // Register or I/O index
    logic [2:0] bsel;                   // Bit or flag select
    logic [6:0] k;                      // Branch offset
    logic is_branch;                    // Operation is a branch
    logic taken;                        // Branch condition met
    logic [15:0] next_pc;               // Counter after this op
    logic alu_wr;                       // ALU writes a register
    logic [7:0] alu_reg;                // ALU register result
    logic [7:0] alu_io;                 // ALU I/O result
    logic [7:0] alu_stat;               // ALU status result
    logic two_cycle;                    // Op needs a second cycle

    // ------------------------------------------------------------
    // Instruction fields and execution units
    // ------------------------------------------------------------
    assign op = cmd_q[FBO_OP_LSB +: 4];
    assign idx = cmd_q[FBO_IDX_LSB +: 5];
    assign bsel = cmd_q[FBO_SEL_LSB +: 3];
    assign k = cmd_q[FBO_K_LSB +: 7];

    // Branch condition and target
    fbo_branch_unit u_branch (
        .op_in(op),
        .k_in(k),
        .stat_in(stat_q),
        .pc_in(pc_q),
        .is_branch_out(is_branch),
        .taken_out(taken),
        .next_pc_out(next_pc)
    );

    // Shift, swap, flag and I/O bit results
    fbo_bit_alu u_alu (
        .op_in(op),
        .sel_in(bsel),
        .reg_in(gpr_q[idx]),
        .io_in(io_q[idx]),
        .stat_in(stat_q),
        .writes_reg_out(alu_wr),
        .reg_out(alu_reg),
        .io_out(alu_io),
        .stat_out(alu_stat)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign bus_req = WB_CYC_IN & WB_STB_IN & ~ack_q;
    assign bus_wr = bus_req & WB_WE_IN;
    assign bus_wr_idle = bus_wr & (state_q == ST_IDLE);
    assign cmd_go = bus_wr_idle & WB_SEL_IN[0]
                    & (WB_ADR_IN == FBO_OFS_CMD);
    assign bus_idx = fbo_word_idx(WB_ADR_IN);
    assign wr_gpr = bus_wr_idle & WB_SEL_IN[0]
                    & fbo_in_region(WB_ADR_IN, FBO_REGION_GPR);
    assign wr_io = bus_wr_idle & WB_SEL_IN[0]
                   & fbo_in_region(WB_ADR_IN, FBO_REGION_IO);

    // Bus acknowledge, one cycle after each new access
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    // Read multiplexer; unmapped addresses read as zero
    always_comb begin
        rd_data = 32'h00000000;
        if (WB_ADR_IN == FBO_OFS_CMD) begin
            rd_data[FBO_CMD_W-1:0] = cmd_q;
        end else if (WB_ADR_IN == FBO_OFS_PC) begin
            rd_data[15:0] = pc_q;
        end else if (WB_ADR_IN == FBO_OFS_STAT) begin
            rd_data[7:0] = stat_q;
        end else if (WB_ADR_IN == FBO_OFS_STATE) begin
            rd_data[3:0] = {last_taken_q, last_cyc_q, busy_q};
        end else if (fbo_in_region(WB_ADR_IN, FBO_REGION_GPR)) begin
            rd_data[7:0] = gpr_q[bus_idx];
        end else if (fbo_in_region(WB_ADR_IN, FBO_REGION_IO)) begin
            rd_data[7:0] = io_q[bus_idx];
        end
    end

    // Read data register, loaded with each new read
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rd_data_q <= 32'h00000000;
        end else if (bus_req & ~WB_WE_IN) begin
            rd_data_q <= rd_data;
        end
    end

    // ------------------------------------------------------------
    // Execution sequencer
    // ------------------------------------------------------------
    // taken branch or I/O bit set/clear needs second cycle
    assign two_cycle = (is_branch & taken)
                       | (op == FBO_OP_IO_SET) | (op == FBO_OP_IO_CLR);

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (cmd_go) begin
                    state_d = ST_EXEC1;
                end
            end
            ST_EXEC1: begin
                state_d = two_cycle ? ST_EXEC2 : ST_IDLE;
            end
            ST_EXEC2: begin
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Sequencer and busy flag
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q <= (state_d != ST_IDLE);
        end
    end

    // Instruction capture; ignored while executing
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            cmd_q <= '0;
        end else if (cmd_go) begin
            cmd_q <= WB_DAT_IN[FBO_CMD_W-1:0];
        end
    end

    // Record of the last instruction's timing
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            last_cyc_q <= 2'h0;
            last_taken_q <= 1'b0;
        end else if (state_q == ST_EXEC1) begin
            last_cyc_q <= two_cycle ? FBO_CYC_TWO : FBO_CYC_ONE;
            last_taken_q <= is_branch & taken;
        end
    end

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------
    // Every op advances; a taken branch loads the target
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pc_q <= FBO_PC_RST;
        end else if (state_q == ST_EXEC1) begin
            // target PC plus k plus one
            pc_q <= next_pc;
        end else if (bus_wr_idle & (WB_ADR_IN == FBO_OFS_PC)) begin
            if (WB_SEL_IN[0]) begin
                pc_q[7:0] <= WB_DAT_IN[7:0];
            end
            if (WB_SEL_IN[1]) begin
                pc_q[15:8] <= WB_DAT_IN[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------
    // Branches, I/O bit ops and swap leave the flags as they are
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            stat_q <= FBO_STAT_RST;
        end else if (state_q == ST_EXEC1) begin
            stat_q <= alu_stat;
        end else if (bus_wr_idle & WB_SEL_IN[0]
                     & (WB_ADR_IN == FBO_OFS_STAT)) begin
            stat_q <= WB_DAT_IN[7:0];
        end
    end

    // ------------------------------------------------------------
    // Working registers
    // ------------------------------------------------------------
    // Single-cycle shift, rotate and swap write back
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            for (int i = 0; i < 32; i++) begin
                gpr_q[i] <= FBO_BYTE_RST;
            end
        end else if ((state_q == ST_EXEC1) & alu_wr) begin
            gpr_q[idx] <= alu_reg;
        end else if (wr_gpr) begin
            gpr_q[bus_idx] <= WB_DAT_IN[7:0];
        end
    end

    // ------------------------------------------------------------
    // I/O registers
    // ------------------------------------------------------------
    // Read-modify-write: modify in first cycle, write in second
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            io_hold_q <= FBO_BYTE_RST;
        end else if (state_q == ST_EXEC1) begin
            io_hold_q <= alu_io;
        end
    end

    // I/O array write port
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            for (int i = 0; i < 32; i++) begin
                io_q[i] <= FBO_BYTE_RST;
            end
        end else if ((state_q == ST_EXEC2) & ~is_branch) begin
            // set bit lands in cycle two
            // clear bit lands in cycle two
            io_q[idx] <= io_hold_q;
        end else if (wr_io) begin
            io_q[bus_idx] <= WB_DAT_IN[7:0];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign WB_ACK_OUT = ack_q;
    assign WB_DAT_OUT = rd_data_q;
    assign BUSY_OUT = busy_q;

endmodule

// >>> bench/fbo_core_monitor.sv
// Port timing checks for the flag branch and bit unit
`timescale 1ns/10ps
module fbo_core_monitor (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    // Wishbone slave
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [fbo_pkg::FBO_ADR_W-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [fbo_pkg::FBO_DAT_W-1:0] WB_DAT_IN,
    input wire logic [fbo_pkg::FBO_DAT_W-1:0] WB_DAT_OUT,
    input wire logic WB_ACK_OUT,
    // Execution status
    input wire logic BUSY_OUT
);
    import fbo_pkg::*;
    // Request taken at this edge
    logic req;
    // Instruction write that starts an operation
    logic go;
    assign req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    assign go = req && WB_WE_IN && WB_SEL_IN[0] && !BUSY_OUT &&
        WB_ADR_IN == FBO_OFS_CMD;
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);
    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    chk_ack_follows:
        assert property (req |=> WB_ACK_OUT) else $error("no ack");
    chk_ack_pulse:
        assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("long ack");
    chk_unmapped_zero:
        assert property (req && !WB_WE_IN && WB_ADR_IN[9:7] > 3'h2
            |=> WB_DAT_OUT == 32'h0) else $error("unmapped read not zero");
    chk_narrow_read:
        assert property (req && !WB_WE_IN && WB_ADR_IN[9:7] != 3'h0
            |=> WB_DAT_OUT[31:8] == 24'h0) else $error("upper bits set");
    // ----------------------------------------
    // Execution length
    // ----------------------------------------
    chk_busy_start:
        assert property (go |=> BUSY_OUT) else $error("busy not raised");
    chk_busy_cause:
        assert property (!go && !BUSY_OUT |=> !BUSY_OUT)
        else $error("busy without instruction");
    chk_busy_max:
        assert property (BUSY_OUT [*2] |=> !BUSY_OUT)
        else $error("busy over two cycles");
    chk_one_cycle_op:
        assert property (go && WB_DAT_IN[3:0] >= FBO_OP_SHL
            |=> BUSY_OUT ##1 !BUSY_OUT) else $error("not one cycle");
    chk_io_two_cycles:
        assert property (go && (WB_DAT_IN[3:0] == FBO_OP_IO_SET ||
            WB_DAT_IN[3:0] == FBO_OP_IO_CLR)
            |=> BUSY_OUT [*2]) else $error("not two cycles");
endmodule
bind fbo_core fbo_core_monitor u_fbo_core_monitor (
    .CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .WB_CYC_IN(WB_CYC_IN),
    .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
    .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT),
    .WB_ACK_OUT(WB_ACK_OUT), .BUSY_OUT(BUSY_OUT));

// >>> bench/fbo_core_bench.sv
// Self-checking bench for the flag branch and bit unit
`timescale 1ns/10ps
module fbo_core_bench;
    import fbo_pkg::*;
    // Clock, reset and bus drive
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] dat_r;
    logic ack;
    logic busy;
    int n_fail = 0;
    int total_checks = 0;
    // Unit under test
    fbo_core u_fbo_core (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
        .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
        .WB_SEL_IN(sel), .WB_DAT_IN(dat_w), .WB_DAT_OUT(dat_o),
        .WB_ACK_OUT(ack), .BUSY_OUT(busy));
    // 40 MHz clock
    always #12.5 clk = ~clk;
    // Print counts and verdict, then end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    // One classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [9:0] a,
            input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        dat_r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk(n, 2);
    endtask
    // Full word write and checked read
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hF);
        chk(dat_r, e);
    endtask
    // Load operands, run one instruction, compare; tk 1 taken, 2 I/O op
    task automatic run(input logic [3:0] op, input logic [2:0] bs,
            input logic [6:0] k, input logic [9:0] a, input logic [7:0] v,
            input logic [7:0] f, input logic [15:0] pc,
            input logic [7:0] ev, input logic [7:0] ef, input int tk);
        int n;
        logic [15:0] epc;
        epc = pc + 16'h0001 + (tk == 1 ? {{9{k[6]}}, k} : 16'h0000);
        wr(a, {24'h0, v});
        wr(FBO_OFS_STAT, {24'h0, f});
        wr(FBO_OFS_PC, {16'h0, pc});
        wr(FBO_OFS_CMD, {13'h0, k, bs, a[6:2], op});
        n = 0;
        while (busy === 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        chk(n, tk > 0 ? 2 : 1);
        rd(a, {24'h0, ev});
        rd(FBO_OFS_STAT, {24'h0, ef});
        rd(FBO_OFS_PC, {16'h0, epc});
        rd(FBO_OFS_STATE, (tk == 1) ? 32'h0000000C
            : (tk == 2) ? 32'h00000004 : 32'h00000002);
    endtask
    // Reset values, unmapped place, missing byte lane
    task automatic t_reset();
        rd(FBO_OFS_PC, 32'h0);
        rd(FBO_OFS_STAT, 32'h0);
        rd(10'h0FC, 32'h0);
        wr(10'h200, 32'hFF);
        rd(10'h200, 32'h0);
        wb(1'b1, FBO_OFS_STAT, 32'hFF, 4'hE);
        rd(FBO_OFS_STAT, 32'h0);
        $display("reset test done");
    endtask
    // Every branch with its flag high and low, plus a wrapping jump
    task automatic t_branch();
        logic [7:0] m;
        for (int o = 1; o <= 8; o++) begin
            m = 8'h01 << ((o < 3) ? 5 : (o < 5) ? 6 : (o < 7) ? 3 : 7);
            run(o[3:0], 3'h0, 7'h7E, 10'h080, 8'h33, m, 16'h0010,
                8'h33, m, o[0] ? 1 : 0);
            run(o[3:0], 3'h0, 7'h7E, 10'h080, 8'h33, ~m, 16'h0010,
                8'h33, ~m, o[0] ? 0 : 1);
        end
        run(FBO_OP_BR_I_SET, 3'h0, 7'h3F, 10'h080, 8'h00, 8'h80,
            16'hFFF0, 8'h00, 8'h80, 1);
        $display("branch test done");
    endtask
    // I/O bit set and clear at the top index
    task automatic t_io();
        run(FBO_OP_IO_SET, 3'h7, 7'h00, 10'h17C, 8'h5A, 8'hA5,
            16'h0100, 8'hDA, 8'hA5, 2);
        run(FBO_OP_IO_CLR, 3'h1, 7'h00, 10'h17C, 8'hDA, 8'hA5,
            16'h0100, 8'hD8, 8'hA5, 2);
        $display("io test done");
    endtask
    // Shifts, rotate, swap and flag set
    task automatic t_shift();
        run(FBO_OP_SHL, 3'h0, 7'h00, 10'h0FC, 8'h81, 8'h30,
            16'h0000, 8'h02, 8'h39, 0);
        run(FBO_OP_SHL, 3'h0, 7'h00, 10'h0FC, 8'h40, 8'h00,
            16'h0000, 8'h80, 8'h0C, 0);
        run(FBO_OP_SHR, 3'h0, 7'h00, 10'h080, 8'h01, 8'h30,
            16'h0000, 8'h00, 8'h3B, 0);
        run(FBO_OP_ROT, 3'h0, 7'h00, 10'h080, 8'h80, 8'h31,
            16'h0000, 8'h01, 8'h39, 0);
        run(FBO_OP_ROT, 3'h0, 7'h00, 10'h080, 8'h80, 8'h00,
            16'h0000, 8'h00, 8'h0B, 0);
        run(FBO_OP_SWAP, 3'h0, 7'h00, 10'h084, 8'hA5, 8'h5F,
            16'h0000, 8'h5A, 8'h5F, 0);
        run(FBO_OP_FLAG_SET, 3'h4, 7'h00, 10'h084, 8'h11, 8'h00,
            16'h0000, 8'h11, 8'h10, 0);
        run(FBO_OP_FLAG_SET, 3'h7, 7'h00, 10'h084, 8'h11, 8'h01,
            16'h0000, 8'h11, 8'h81, 0);
        run(FBO_OP_NOP, 3'h0, 7'h00, 10'h084, 8'h11, 8'h81,
            16'h0000, 8'h11, 8'h81, 0);
        $display("shift test done");
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_branch();
        t_io();
        t_shift();
        stop_test();
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        stop_test();
    end
endmodule
